// ==== design/usbbd_dma.sv ====
// Purpose: Descriptor claim, data move and status writeback for the
//          serial engine, over its own DMA master port into RAM.
// Assumes: Engine logic on ref_clk; RAM answers each request by mem_ack.
// Notes: Ownership is read from RAM each transfer; nothing is cached.
`timescale 1ns/100ps

// What this block does
// - Each descriptor index is tied to one endpoint and direction by mode.
// - Mode 0 uses 2n for receive and 2n+1 for transmit.
// - Mode 1 alternates endpoint 0 receive on 0/1; others shift by one.
// - Mode 2 uses 4n..4n+3, even/odd receive then even/odd transmit.
// - Mode 3 keeps endpoint 0 single; others use 4n-2 onward.
// - Ownership flag set means engine owns; clear means CPU owns.
// - Status word stays readable by the non-owning party.
// - Status word meaning depends on owner; only the ownership, toggle and count fields are shared.
// - Engine overwrites the status word with packet identifier and count.
// - One dedicated DMA port does all table and buffer accesses.
// - Device use writes the received token identifier.
// - Host use writes the returned identifier or a status code.
// - Byte count gives bytes to send or most bytes to accept.
// - On completion byte count becomes bytes actually moved.
// - Table sits 512-byte aligned; pointer holds upper address byte.
// - Descriptor is status word plus address word; 64 descriptors.
// - Selection depends on endpoint, direction and two-bit mode.
// - Host use takes endpoint 0 descriptors for every transfer.
module usbbd_dma
    import usbbd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [7:0] table_ptr,
    input wire logic [1:0] pingpong_mode,
    input wire logic host_mode,
    input wire logic pp_reset,
    input wire logic xfer_req,
    input wire logic [EP_W-1:0] xfer_ep,
    input wire logic xfer_dir,
    input wire logic [PID_W-1:0] token_pid,
    input wire logic xfer_end,
    input wire logic [PID_W-1:0] result_pid,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic mem_req,
    output logic mem_we,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [WORD_W-1:0] mem_wdata,
    output logic [1:0] mem_be,
    input wire logic mem_ack,
    input wire logic [WORD_W-1:0] mem_rdata,
    output logic xfer_busy,
    output logic desc_grant,
    output logic desc_not_owned,
    output logic desc_stall,
    output logic desc_toggle,
    output logic desc_sync_en,
    output logic [IDX_W-1:0] desc_index,
    output logic [BC_W-1:0] desc_max_count,
    output logic xfer_done,
    output logic [BC_W-1:0] xfer_count
);

    // ************************************************
    // State
    // ************************************************
    usbbd_state_e state_q;
    logic [EP_W-1:0] ep_q;
    logic dir_q;
    logic [PID_W-1:0] pid_q;
    logic pp_en_q;
    logic [IDX_W-1:0] idx_q;
    logic tog_q;
    logic sync_q;
    logic [BC_W-1:0] max_q;
    logic [BC_W-1:0] cnt_q;
    logic [ADDR_W-1:0] buf_q;
    logic [PP_ENTRIES-1:0] pp_odd_q;
    logic tx_valid_q;
    logic [7:0] tx_data_q;
    logic rx_ready_q;
    logic mem_req_q;
    logic mem_we_q;
    logic [ADDR_W-1:0] mem_addr_q;
    logic [WORD_W-1:0] mem_wdata_q;
    logic [1:0] mem_be_q;
    logic grant_q;
    logic not_owned_q;
    logic stall_q;
    logic done_q;
    logic [BC_W-1:0] count_q;

    // ************************************************
    // Descriptor selection and addressing
    // ************************************************
    // Host traffic always lands on endpoint 0 descriptors
    wire [EP_W-1:0] ep_eff = host_mode ? 4'h0 : xfer_ep;
    wire [4:0] pp_sel_req = {ep_eff, xfer_dir};
    wire [4:0] pp_sel_q = {ep_q, dir_q};
    wire map_odd = pp_odd_q[pp_sel_req];
    wire [IDX_W-1:0] map_idx;
    wire map_pp_en;

    usbbd_map u_map (
        .mode(pingpong_mode),
        .ep(ep_eff),
        .dir(xfer_dir),
        .odd(map_odd),
        .idx(map_idx),
        .pp_en(map_pp_en)
    );

    // Pointer bit 0 is ignored: the table must sit on a 512-byte boundary
    wire [ADDR_W-1:0] tbl_base = {table_ptr[7:1], 9'h000};
    wire [ADDR_W-1:0] stat_addr = tbl_base
        + ADDR_W'({idx_q, 2'b00});
    wire [ADDR_W-1:0] adr_addr = stat_addr + ADDR_WORD_OFS;

    // Byte lane selection for 16-bit RAM words
    wire [ADDR_W-1:0] byte_addr = buf_q + ADDR_W'(cnt_q);
    wire [7:0] rd_byte = mem_addr_q[0] ? mem_rdata[15:8] : mem_rdata[7:0];
    wire [1:0] wr_be = byte_addr[0] ? BE_HI : BE_LO;

    // Status field decode, CPU view on fetch
    wire st_own = mem_rdata[OWN_BIT];
    wire st_stall = mem_rdata[STALL_BIT];
    wire more_room = (cnt_q < max_q);

    // Writeback word in engine view: owner cleared, identifier and count
    wire [PID_W-1:0] wb_pid = host_mode ? result_pid : pid_q;
    wire [WORD_W-1:0] wb_word = {1'b0, tog_q, wb_pid, cnt_q};

    // Ping-pong phase flips only on a completed writeback
    wire pp_flip = (state_q == S_WB) & mem_ack & pp_en_q;

    // ************************************************
    // Ping-pong phase per endpoint direction
    // ************************************************
    for (genvar g = 0; g < PP_ENTRIES; g++) begin : g_pp
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                pp_odd_q[g] <= 1'b0;
            end else if (clk_en) begin
                if (pp_reset) begin
                    pp_odd_q[g] <= 1'b0;
                end else if (pp_flip && pp_sel_q == 5'(g)) begin
                    pp_odd_q[g] <= ~pp_odd_q[g];
                end
            end
        end
    end

    // ************************************************
    // Transfer sequencer
    // ************************************************
    // One-cycle answer pulses drop every enabled cycle unless re-armed
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            ep_q <= '0;
            dir_q <= 1'b0;
            pid_q <= '0;
            pp_en_q <= 1'b0;
            idx_q <= '0;
            tog_q <= 1'b0;
            sync_q <= 1'b0;
            max_q <= '0;
            cnt_q <= '0;
            buf_q <= '0;
            tx_valid_q <= 1'b0;
            tx_data_q <= '0;
            rx_ready_q <= 1'b0;
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= '0;
            mem_wdata_q <= '0;
            mem_be_q <= '0;
            grant_q <= 1'b0;
            not_owned_q <= 1'b0;
            stall_q <= 1'b0;
            done_q <= 1'b0;
            count_q <= '0;
        end else if (clk_en) begin
            grant_q <= 1'b0;
            not_owned_q <= 1'b0;
            stall_q <= 1'b0;
            done_q <= 1'b0;
            rx_ready_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (xfer_req) begin
                        ep_q <= ep_eff;
                        dir_q <= xfer_dir;
                        pid_q <= token_pid;
                        idx_q <= map_idx;
                        pp_en_q <= map_pp_en;
                        cnt_q <= '0;
                        state_q <= S_STAT;
                    end
                end
                S_STAT: begin
                    // Read the status word; RAM stays readable to the CPU
                    mem_req_q <= ~mem_ack;
                    mem_we_q <= 1'b0;
                    mem_addr_q <= stat_addr;
                    mem_be_q <= BE_BOTH;
                    if (mem_req_q && mem_ack) begin
                        if (!st_own) begin
                            not_owned_q <= 1'b1;
                            state_q <= S_IDLE;
                        end else if (st_stall) begin
                            stall_q <= 1'b1; // descriptor left unchanged
                            state_q <= S_IDLE;
                        end else begin
                            tog_q <= mem_rdata[TOG_BIT];
                            sync_q <= mem_rdata[SYNC_BIT];
                            max_q <= mem_rdata[BC_HI:0];
                            state_q <= S_ADDR;
                        end
                    end
                end
                S_ADDR: begin
                    mem_req_q <= ~mem_ack;
                    mem_addr_q <= adr_addr;
                    if (mem_req_q && mem_ack) begin
                        buf_q <= mem_rdata;
                        grant_q <= 1'b1;
                        state_q <= S_XFER;
                    end
                end
                S_XFER: begin
                    if (xfer_end) begin
                        state_q <= S_WB;
                    end else if (dir_q && more_room) begin
                        state_q <= S_TXRD;
                    end else if (!dir_q && rx_valid && !rx_ready_q) begin
                        if (more_room) begin
                            state_q <= S_RXWR;
                        end else begin
                            rx_ready_q <= 1'b1; // Overrun byte dropped
                        end
                    end
                end
                S_TXRD: begin
                    mem_req_q <= ~mem_ack;
                    mem_we_q <= 1'b0;
                    mem_addr_q <= byte_addr;
                    mem_be_q <= BE_BOTH;
                    if (mem_req_q && mem_ack) begin
                        tx_data_q <= rd_byte;
                        tx_valid_q <= 1'b1;
                        state_q <= S_TXOUT;
                    end
                end
                S_TXOUT: begin
                    if (tx_ready) begin
                        tx_valid_q <= 1'b0;
                        cnt_q <= cnt_q + 10'h001;
                        state_q <= S_XFER;
                    end
                end
                S_RXWR: begin
                    mem_req_q <= ~mem_ack;
                    mem_we_q <= ~mem_ack;
                    mem_addr_q <= byte_addr;
                    mem_wdata_q <= {rx_data, rx_data};
                    mem_be_q <= wr_be;
                    if (mem_req_q && mem_ack) begin
                        rx_ready_q <= 1'b1;
                        cnt_q <= cnt_q + 10'h001;
                        state_q <= S_XFER;
                    end
                end
                S_WB: begin
                    // Hand the descriptor back with the engine view
                    mem_req_q <= ~mem_ack;
                    mem_we_q <= ~mem_ack;
                    mem_addr_q <= stat_addr;
                    mem_wdata_q <= wb_word;
                    mem_be_q <= BE_BOTH;
                    if (mem_req_q && mem_ack) begin
                        done_q <= 1'b1;
                        count_q <= cnt_q;
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    mem_req_q <= 1'b0;
                    mem_we_q <= 1'b0;
                    tx_valid_q <= 1'b0;
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // ************************************************
    // Outputs, all from flops
    // ************************************************
    assign tx_valid = tx_valid_q;
    assign tx_data = tx_data_q;
    assign rx_ready = rx_ready_q;
    assign mem_req = mem_req_q;
    assign mem_we = mem_we_q;
    assign mem_addr = mem_addr_q;
    assign mem_wdata = mem_wdata_q;
    assign mem_be = mem_be_q;
    assign desc_grant = grant_q;
    assign desc_not_owned = not_owned_q;
    assign desc_stall = stall_q;
    assign desc_toggle = tog_q; // 1 selects DATA1
    assign desc_sync_en = sync_q;
    assign desc_index = idx_q;
    assign desc_max_count = max_q;
    assign xfer_done = done_q;
    assign xfer_count = count_q;
    // Busy is any state but idle, the inverse of the idle flop bit of the one-hot code
    assign xfer_busy = ~state_q[0];

endmodule // usbbd_dma

// ==== design/usbbd_pkg.sv ====
// Purpose: Shared constants for the buffer descriptor DMA block.
// Assumes: 16-bit byte-addressed RAM, 16-bit descriptor words.
// Notes: Field positions follow the descriptor status word layout.
package usbbd_pkg;

    // ************************************************
    // Widths
    // ************************************************
    localparam int ADDR_W = 16;
    localparam int WORD_W = 16;
    localparam int BC_W = 10;
    localparam int IDX_W = 6;
    localparam int EP_W = 4;
    localparam int PID_W = 4;
    localparam int PP_ENTRIES = 32;

    // ************************************************
    // Descriptor status word fields
    // ************************************************
    localparam int OWN_BIT = 15;
    localparam int TOG_BIT = 14;
    localparam int PID_HI = 13;
    localparam int PID_LO = 10;
    localparam int SYNC_BIT = 11;
    localparam int STALL_BIT = 10;
    localparam int BC_HI = 9;

    // ************************************************
    // Table layout
    // ************************************************
    localparam int BASE_SHIFT = 9;
    localparam int DESC_SHIFT = 2;
    localparam logic [ADDR_W-1:0] ADDR_WORD_OFS = 16'h0002;
    localparam logic [1:0] BE_LO = 2'h1;
    localparam logic [1:0] BE_HI = 2'h2;
    localparam logic [1:0] BE_BOTH = 2'h3;

    // Ping-pong buffering modes
    typedef enum logic [1:0] {
        PP_NONE = 2'h0,
        PP_EP0_RX = 2'h1,
        PP_ALL = 2'h2,
        PP_NOT_EP0 = 2'h3
    } usbbd_mode_e;

    // Engine sequencer states, one-hot
    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_STAT = 8'h02,
        S_ADDR = 8'h04,
        S_XFER = 8'h08,
        S_TXRD = 8'h10,
        S_TXOUT = 8'h20,
        S_RXWR = 8'h40,
        S_WB = 8'h80
    } usbbd_state_e;

endpackage

// ==== design/usbbd_map.sv ====
// Purpose: Maps endpoint, direction and ping-pong phase to a descriptor.
// Assumes: Pure combinational, endpoint already forced to 0 in host use.
// Notes: pp_en says whether this endpoint direction alternates.
`timescale 1ns/100ps
module usbbd_map
    import usbbd_pkg::*;
(
    input wire logic [1:0] mode,
    input wire logic [EP_W-1:0] ep,
    input wire logic dir,
    input wire logic odd,
    output logic [IDX_W-1:0] idx,
    output logic pp_en
);

    // ************************************************
    // Per-mode index candidates
    // ************************************************
    wire ep0 = (ep == 4'h0);
    wire [IDX_W-1:0] n2 = {1'b0, ep, 1'b0};
    wire [IDX_W-1:0] n4 = {ep, 2'b00};
    wire [IDX_W-1:0] dir1 = {5'h00, dir};
    wire [IDX_W-1:0] odd1 = {5'h00, odd};
    // Mode 0: 2n receive, 2n+1 transmit
    wire [IDX_W-1:0] idx_m0 = n2 + dir1;
    // Mode 1: only endpoint 0 receive alternates
    wire [IDX_W-1:0] idx_m1 = ep0 ? (dir ? 6'h02 : odd1)
                                  : (n2 + 6'h01 + dir1);
    // Mode 2: four descriptors per endpoint
    wire [IDX_W-1:0] idx_m2 = n4 + {4'h0, dir, odd};
    // Mode 3: endpoint 0 single, others alternate
    wire [IDX_W-1:0] idx_m3 = ep0 ? dir1
                            : (n4 - (dir ? 6'h00 : 6'h02) + odd1);

    // Fixed relation of index to endpoint, never reassigned at run time
    assign idx = (mode == PP_NONE) ? idx_m0 :
                 (mode == PP_EP0_RX) ? idx_m1 :
                 (mode == PP_ALL) ? idx_m2 : idx_m3;
    assign pp_en = (mode == PP_EP0_RX) ? (ep0 & ~dir) :
                   (mode == PP_ALL) ? 1'b1 :
                   (mode == PP_NOT_EP0) ? ~ep0 : 1'b0;

endmodule // usbbd_map

// ==== bench/usbbd_dma_checker.sv ====
// Purpose: Port assertions for the descriptor DMA.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes: Attached to every usbbd_dma instance by the bind below.
`timescale 1ns/100ps
module usbbd_dma_checker
    import usbbd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] table_ptr,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [WORD_W-1:0] mem_wdata,
    input wire logic [1:0] mem_be,
    input wire logic mem_ack,
    input wire logic [WORD_W-1:0] mem_rdata,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic xfer_busy,
    input wire logic desc_not_owned,
    input wire logic desc_stall,
    input wire logic desc_toggle,
    input wire logic xfer_done,
    input wire logic [BC_W-1:0] xfer_count
);
    // **********
    // Properties
    // **********
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_req_held: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("memory request changed before ack");
    chk_stat_first: assert property (
        $rose(xfer_busy) |=> mem_req && !mem_we
        && mem_addr[15:9] == table_ptr[7:1] && mem_addr[1:0] == 2'h0)
        else $error("first access is not a table status read");
    chk_done_idle: assert property (
        xfer_done |-> !xfer_busy ##1 !xfer_done)
        else $error("done pulse wrong");
    chk_wb_word: assert property (
        xfer_done |-> $past(mem_ack) && $past(mem_we)
        && $past(mem_be) == BE_BOTH && !$past(mem_wdata[OWN_BIT]))
        else $error("writeback word wrong");
    chk_wb_count: assert property (
        xfer_done |-> $past(mem_wdata[BC_HI:0]) == xfer_count)
        else $error("written count differs from reported count");
    chk_wb_toggle: assert property (
        xfer_done |-> $past(mem_wdata[TOG_BIT]) == desc_toggle)
        else $error("toggle changed on writeback");
    chk_tx_hold: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("transmit byte dropped before ready");
    chk_idle_quiet: assert property (
        !xfer_busy |-> !mem_req && !tx_valid)
        else $error("activity while idle");
    chk_own_clear: assert property (
        desc_not_owned |-> $past(mem_ack) && !$past(mem_rdata[OWN_BIT]))
        else $error("not owned without clear flag");
    chk_stall_seen: assert property (
        desc_stall |-> $past(mem_rdata[STALL_BIT]) && !xfer_busy)
        else $error("stall answer without stall bit");
endmodule // usbbd_dma_checker

bind usbbd_dma usbbd_dma_checker CHK (.ref_clk(ref_clk), .rst_n(rst_n),
    .table_ptr(table_ptr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .xfer_busy(xfer_busy),
    .desc_not_owned(desc_not_owned), .desc_stall(desc_stall),
    .desc_toggle(desc_toggle), .xfer_done(xfer_done),
    .xfer_count(xfer_count));

// ==== bench/usbbd_ram_model.sv ====
// Purpose: Shared RAM seen by the engine DMA and the CPU side.
// Assumes: Byte addresses, 16-bit words, lane chosen by mem_be.
// Notes: Answers after a random wait so both fast and slow acks occur.
`timescale 1ns/100ps
module usbbd_ram_model
    import usbbd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [WORD_W-1:0] mem_wdata,
    input wire logic [1:0] mem_be,
    output logic mem_ack,
    output logic [WORD_W-1:0] mem_rdata
);
    // One flat array, so the table is one contiguous range
    logic [WORD_W-1:0] mem [0:32767];
    logic [14:0] wa;
    assign wa = mem_addr[15:1];

    // Read data is only good with ack; otherwise it flips every cycle
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0000;
        end else if (mem_req && !mem_ack && ($urandom % 3 != 0)) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[wa];
            if (mem_we && mem_be[0])
                mem[wa][7:0] <= mem_wdata[7:0];
            if (mem_we && mem_be[1])
                mem[wa][15:8] <= mem_wdata[15:8];
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule // usbbd_ram_model

// ==== bench/usbbd_dma_tb.sv ====
// Purpose: Self-checking bench for the descriptor DMA.
// Assumes: CPU writes descriptors straight into the RAM model array.
// Notes: Descriptors are touched only while the engine is idle.
`timescale 1ns/100ps
module usbbd_dma_tb
    import usbbd_pkg::*;
;
    logic ref_clk = 1'b0, rst_n = 1'b0, host_mode = 1'b0, pp_reset = 1'b0;
    logic xfer_req = 1'b0, xfer_dir = 1'b0, xfer_end = 1'b0, clk_en = 1'b1;
    logic tx_ready = 1'b0, rx_valid = 1'b0;
    logic [7:0] table_ptr = 8'h80, rx_data = 8'h00, tx_data;
    logic [1:0] pingpong_mode = 2'h0, mem_be;
    logic [3:0] xfer_ep = 4'h0, token_pid = 4'h0, result_pid = 4'h0;
    logic tx_valid, rx_ready, mem_req, mem_we, mem_ack, xfer_busy;
    logic desc_grant, desc_not_owned, desc_stall, desc_toggle, desc_sync_en;
    logic xfer_done;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, base;
    logic [5:0] desc_index;
    logic [9:0] desc_max_count, xfer_count;
    int bad_count = 0, check_count = 0, cyc = 0;
    int ph [32];

    usbbd_dma DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .table_ptr(table_ptr), .pingpong_mode(pingpong_mode),
        .host_mode(host_mode), .pp_reset(pp_reset), .xfer_req(xfer_req),
        .xfer_ep(xfer_ep), .xfer_dir(xfer_dir), .token_pid(token_pid),
        .xfer_end(xfer_end), .result_pid(result_pid), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_be(mem_be), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .xfer_busy(xfer_busy), .desc_grant(desc_grant),
        .desc_not_owned(desc_not_owned), .desc_stall(desc_stall),
        .desc_toggle(desc_toggle), .desc_sync_en(desc_sync_en),
        .desc_index(desc_index), .desc_max_count(desc_max_count),
        .xfer_done(xfer_done), .xfer_count(xfer_count));
    usbbd_ram_model RAM (.ref_clk(ref_clk), .rst_n(rst_n),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));

    // ********
    // Helpers
    // ********
    task automatic chk(input string what, input logic [15:0] exp, got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Sample one step after the edge so registered outputs have settled
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask

    // Reference mapping of endpoint, direction and phase to descriptor
    function automatic int exp_idx(int m, e, d, o);
        case (m)
            0: return 2 * e + d;
            1: return (e == 0) ? (d ? 2 : o) : 2 * e + 1 + d;
            2: return 4 * e + 2 * d + o;
            default: return (e == 0) ? d : 4 * e - 2 + 2 * d + o;
        endcase
    endfunction

    function automatic int pp_on(int m, e, d);
        return (m == 2) || (m == 1 && e == 0 && d == 0) || (m == 3 && e != 0);
    endfunction

    // One transaction: set descriptor, request, move data, check writeback
    task automatic run(input int m, h, ep, d, own, stl, cnt, n);
        int e, i, k, b, nb, sa;
        logic [15:0] st, ba, wb;
        logic [7:0] q [$];
        logic [3:0] tp, rp;
        logic tg, sy;
        e = h ? 0 : ep;
        i = exp_idx(m, e, d, ph[2 * e + d]);
        sa = (base + 4 * i) >> 1;
        tg = 1'($urandom);
        sy = 1'($urandom);
        tp = 4'($urandom);
        rp = 4'($urandom);
        ba = 16'h1000 + 16'(i * 64); // Buffers kept clear of the table
        st = {own[0], tg, 2'h0, sy, stl[0], 10'(cnt)};
        RAM.mem[sa] = st;
        RAM.mem[sa + 1] = ba;
        for (b = 0; b < 32; b++)
            RAM.mem[ba[15:1] + b] = 16'($urandom);
        @(posedge ref_clk);
        pingpong_mode <= 2'(m);
        host_mode <= h[0];
        xfer_ep <= 4'(ep);
        xfer_dir <= d[0];
        token_pid <= tp;
        result_pid <= rp;
        xfer_req <= 1'b1;
        @(posedge ref_clk) xfer_req <= 1'b0;
        for (k = 0; k < 60 && !(desc_grant | desc_not_owned | desc_stall); k++)
            tick();
        chk("answer", {!own[0], own[0] & stl[0], own[0] & !stl[0]},
            {desc_not_owned, desc_stall, desc_grant});
        if (!own || stl) begin
            tick();
            chk("untouched", st, RAM.mem[sa]);
            return;
        end
        chk("index", i, desc_index);
        chk("max", cnt, desc_max_count);
        chk("toggle", tg, desc_toggle);
        chk("sync", sy, desc_sync_en);
        nb = d ? cnt : (n < cnt ? n : cnt);
        for (b = 0; d && b < cnt; b++) begin
            for (k = 0; k < 60 && tx_valid !== 1'b1; k++)
                tick();
            wb = RAM.mem[ba[15:1] + b / 2];
            chk("tx byte", b[0] ? wb[15:8] : wb[7:0], tx_data);
            repeat ($urandom % 3) @(posedge ref_clk);
            @(posedge ref_clk) tx_ready <= 1'b1;
            @(posedge ref_clk) tx_ready <= 1'b0;
            tick();
        end
        for (b = 0; !d && b < n; b++) begin
            wb = 16'($urandom);
            q.push_back(wb[7:0]);
            @(posedge ref_clk);
            rx_valid <= 1'b1;
            rx_data <= wb[7:0];
            // Last pulse may still stand here; wait past it first
            tick();
            for (k = 0; k < 60 && rx_ready !== 1'b1; k++)
                tick();
        end
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
        repeat (3) @(posedge ref_clk);
        xfer_end <= 1'b1;
        @(posedge ref_clk) xfer_end <= 1'b0;
        for (k = 0; k < 60 && xfer_done !== 1'b1; k++)
            tick();
        chk("count", nb, xfer_count);
        chk("status", {1'b0, tg, h ? rp : tp, 10'(nb)},
            RAM.mem[sa]);
        for (b = 0; !d && b < nb; b++) begin
            wb = RAM.mem[ba[15:1] + b / 2];
            chk("rx byte", q[b], b[0] ? wb[15:8] : wb[7:0]);
        end
        if (pp_on(m, e, d))
            ph[2 * e + d] ^= 1;
    endtask

    // ********
    // Sequence
    // ********
    always #10 ref_clk = ~ref_clk;

    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end

    initial begin
        int m, r, ep;
        void'($urandom(32'hFC9636DF));
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (m = 0; m < 4; m++) begin
            @(posedge ref_clk);
            table_ptr <= 8'h80 | 8'($urandom);
            pp_reset <= 1'b1;
            @(posedge ref_clk) pp_reset <= 1'b0;
            base = {table_ptr[7:1], 9'h000};
            ph = '{default: 0};
            // Endpoints 0 and 15, each direction twice in a row to see both phases; then four random endpoints
            for (r = 0; r < 12; r++) begin
                ep = (r < 4) ? 0 : (r < 8) ? 15 : $urandom % 16;
                run(m, 0, ep, (r >> 1) & 1, 1, 0, $urandom % 7, $urandom % 9);
            end
        end
        // Refusals must not advance the phase; then host traffic
        run(2, 0, 5, 1, 0, 0, 3, 0);
        run(2, 0, 5, 1, 1, 1, 3, 0);
        run(2, 0, 5, 1, 1, 0, 0, 0);
        // Phase clear during a frozen cycle must be ignored
        @(posedge ref_clk);
        clk_en <= 1'b0;
        pp_reset <= 1'b1;
        @(posedge ref_clk);
        clk_en <= 1'b1;
        pp_reset <= 1'b0;
        run(2, 0, 5, 1, 1, 0, 2, 0);
        run(1, 1, 9, 0, 1, 0, 4, 6);
        run(1, 1, 3, 0, 1, 0, 5, 2);
        run(3, 1, 7, 1, 1, 0, 2, 0);
        print_verdict();
    end
endmodule // usbbd_dma_tb
